// ---- csf_pkg.sv ----
// Package for the converter status flag register bank
`default_nettype none
package csf_pkg;
	localparam logic [7:0] STATUS_ADDR = 8'h18;
	localparam logic [7:0] ERRCFG_ADDR = 8'h19;
	localparam int WD_BIT = 11;
	localparam int AH_BIT = 10;
	localparam int AL_BIT = 9;
	localparam int ZC_BIT = 8;
	localparam int RDY_BIT = 6;
	localparam int CH_LSB = 14;
	localparam int UR_BIT = 13;
	localparam int OR_BIT = 12;
	// Error configuration bits
	localparam int CFG_UR_OUT = 15;
	localparam int CFG_OR_OUT = 14;
	localparam int CFG_WD_OUT = 13;
	localparam int CFG_AH_OUT = 12;
	localparam int CFG_AL_OUT = 11;
	localparam int CFG_UR_INT = 7;
	localparam int CFG_OR_INT = 6;
	localparam int CFG_WD_INT = 5;
	localparam int CFG_AH_INT = 4;
	localparam int CFG_AL_INT = 3;
	localparam int CFG_ZC_INT = 2;
	localparam int CFG_RDY_INT = 0;
	localparam logic [15:0] ERRCFG_RESET = 16'h0000;
	localparam logic [15:0] ERRCFG_WMASK = 16'hf8fd;
	// Per-channel error event bundle from the conversion core
	typedef struct packed {
		logic watchdog;
		logic amp_high;
		logic amp_low;
		logic zero_count;
	} csf_err_s;
	// Host register access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} csf_req_s;
endpackage
`default_nettype wire

// ---- csf_status.sv ----
// Status and error-flag register bank of the converter
// Function
// [R01] Watchdog timeout on an active channel sets status bit 11.
// [R02] Amplitude above about 1.8 V on an active channel sets bit 10.
// [R03] Host should lower sensor drive current after an amplitude-high flag.
// [R04] Amplitude below about 1.2 V on an active channel sets bit 9.
// [R05] Zero-count error on an active channel sets bit 8.
// [R06] Error flags are sticky and cleared by reading status.
// [R07] Setting an error flag records its source channel in bits 15:14.
// [R08] Status bits 7 and 5:4 always read zero.
// [R09] Single-channel mode: data ready sets on one new result.
// [R10] Sequential mode: data ready sets once all active channels have fresh results.
// [R11] Bits 3..0 flag unread results of channels 0..3.
// [R12] Host reads upper and lower result words to retrieve a result.
// [R13] Errors hold until status or source channel upper word is read.
// [R14] Config bits 15:11 route error types into result upper words.
// [R15] Config bits 7:2 and 0 gate interrupt pin and status flag updates; bits 7:6 are stored but gate nothing here.
// [R16] Unread flag clears after both result words of the channel are read.
// [R17] Writes to the status register are ignored.
`default_nettype none
module csf_status
	import csf_pkg::*;
#(
	parameter int NCH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Host register access
	input wire csf_req_s req_i,
	output logic [15:0] rdata_o,
	// Result word reads per channel
	input wire logic [NCH-1:0] rd_upper_i,
	input wire logic [NCH-1:0] rd_lower_i,
	// Conversion core events
	input wire logic [NCH-1:0] active_i,
	input wire logic sequential_i,
	input wire logic [NCH-1:0] result_i,
	input wire csf_err_s [NCH-1:0] err_i,
	input wire logic under_range_i,
	input wire logic over_range_i,
	// Outputs
	output logic [4:0] to_result_o,
	output logic interrupt_out_n_o
);
	// ************
	// Registers
	// ************
	logic [15:0] errcfg_q;
	logic watchdog_timeout_flag_q, amplitude_high_flag_q, amplitude_low_flag_q;
	logic zero_count_flag_q, result_ready_flag_q;
	logic [1:0] error_source_channel_q;
	logic [NCH-1:0] unread_q, upper_seen_q, lower_seen_q, fresh_q;
	logic st_rd, src_rd;
	logic ev_wd, ev_ah, ev_al, ev_zc, any_ev;
	logic [1:0] ev_ch;
	logic all_fresh;

	assign st_rd = req_i.rd && req_i.addr == STATUS_ADDR;
	assign src_rd = rd_upper_i[error_source_channel_q];

	// ************
	// Event gather
	// ************
	always_comb begin
		ev_wd = 1'b0;
		ev_ah = 1'b0;
		ev_al = 1'b0;
		ev_zc = 1'b0;
		ev_ch = 2'h0;
		for (int c = NCH - 1; c >= 0; c--) begin
			// Source channel only from error types that are enabled
			if (active_i[c] && (|(err_i[c] & {errcfg_q[CFG_WD_INT], errcfg_q[CFG_AH_INT],
					errcfg_q[CFG_AL_INT], errcfg_q[CFG_ZC_INT]}))) begin
				ev_ch = 2'(c); // R07
			end
			ev_wd = ev_wd | (active_i[c] & err_i[c].watchdog); // R01
			ev_ah = ev_ah | (active_i[c] & err_i[c].amp_high); // R02
			ev_al = ev_al | (active_i[c] & err_i[c].amp_low); // R04
			ev_zc = ev_zc | (active_i[c] & err_i[c].zero_count); // R05
		end
		ev_wd = ev_wd & errcfg_q[CFG_WD_INT]; // R15
		ev_ah = ev_ah & errcfg_q[CFG_AH_INT]; // R15
		ev_al = ev_al & errcfg_q[CFG_AL_INT]; // R15
		ev_zc = ev_zc & errcfg_q[CFG_ZC_INT]; // R15
	end
	assign any_ev = ev_wd | ev_ah | ev_al | ev_zc;

	// ************
	// Error flags, set wins over clear
	// ************
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			watchdog_timeout_flag_q <= 1'b0;
			amplitude_high_flag_q <= 1'b0;
			amplitude_low_flag_q <= 1'b0;
			zero_count_flag_q <= 1'b0;
		end else begin
			if (st_rd || src_rd) begin // R06 R13
				watchdog_timeout_flag_q <= ev_wd;
				amplitude_high_flag_q <= ev_ah;
				amplitude_low_flag_q <= ev_al;
				zero_count_flag_q <= ev_zc;
			end else begin
				watchdog_timeout_flag_q <= watchdog_timeout_flag_q | ev_wd; // R01
				amplitude_high_flag_q <= amplitude_high_flag_q | ev_ah; // R02
				amplitude_low_flag_q <= amplitude_low_flag_q | ev_al; // R04
				zero_count_flag_q <= zero_count_flag_q | ev_zc; // R05
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			error_source_channel_q <= 2'h0;
		end else if (any_ev) begin
			error_source_channel_q <= ev_ch; // R07
		end
	end

	// ************
	// Unread results and data ready
	// ************
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			unread_q <= '0;
			upper_seen_q <= '0;
			lower_seen_q <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (result_i[c]) begin
					unread_q[c] <= 1'b1; // R11
					upper_seen_q[c] <= 1'b0;
					lower_seen_q[c] <= 1'b0;
				end else if ((upper_seen_q[c] | rd_upper_i[c])
						&& (lower_seen_q[c] | rd_lower_i[c])) begin
					unread_q[c] <= 1'b0; // R16
					upper_seen_q[c] <= 1'b0;
					lower_seen_q[c] <= 1'b0;
				end else begin
					upper_seen_q[c] <= upper_seen_q[c] | rd_upper_i[c];
					lower_seen_q[c] <= lower_seen_q[c] | rd_lower_i[c];
				end
			end
		end
	end

	assign all_fresh = active_i != '0 && ((fresh_q | result_i) & active_i) == active_i;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			fresh_q <= '0;
			result_ready_flag_q <= 1'b0;
		end else begin
			if (sequential_i && all_fresh) begin
				fresh_q <= '0; // R10
			end else if (sequential_i) begin
				fresh_q <= fresh_q | (result_i & active_i);
			end else begin
				fresh_q <= '0;
			end
			if (errcfg_q[CFG_RDY_INT] && (sequential_i ? all_fresh
					: |(result_i & active_i))) begin
				result_ready_flag_q <= 1'b1; // R09 R10 R15
			end else if (st_rd) begin
				result_ready_flag_q <= 1'b0;
			end
		end
	end

	// ************
	// Configuration register; status writes ignored
	// ************
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			errcfg_q <= ERRCFG_RESET;
		end else if (req_i.wr && req_i.addr == ERRCFG_ADDR) begin
			errcfg_q <= req_i.wdata & ERRCFG_WMASK; // R17
		end
	end

	// Read data registered one cycle after the read
	logic [15:0] status_w;
	logic [3:0] unread_w;
	always_comb begin
		unread_w = 4'h0;
		for (int c = 0; c < NCH && c < 4; c++) begin
			unread_w[3-c] = unread_q[c]; // R11
		end
		status_w = 16'h0000; // R08
		status_w[CH_LSB +: 2] = error_source_channel_q;
		status_w[UR_BIT] = 1'b0;
		status_w[OR_BIT] = 1'b0;
		status_w[WD_BIT] = watchdog_timeout_flag_q;
		status_w[AH_BIT] = amplitude_high_flag_q;
		status_w[AL_BIT] = amplitude_low_flag_q;
		status_w[ZC_BIT] = zero_count_flag_q;
		status_w[RDY_BIT] = result_ready_flag_q;
		status_w[3:0] = unread_w;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_o <= 16'h0000;
		end else if (req_i.rd) begin
			rdata_o <= req_i.addr == STATUS_ADDR ? status_w
				: req_i.addr == ERRCFG_ADDR ? errcfg_q : 16'h0000;
		end
	end

	assign to_result_o = errcfg_q[CFG_UR_OUT:CFG_AL_OUT]; // R14
	assign interrupt_out_n_o = !(watchdog_timeout_flag_q | amplitude_high_flag_q
		| amplitude_low_flag_q | zero_count_flag_q | result_ready_flag_q); // R15

	// ************
	// Assertions
	// ************
	chk_wd_sets: assert property (@(posedge clk_i) disable iff (!resetn_i) // R01
		ev_wd |=> watchdog_timeout_flag_q) else $error("watchdog flag not set");
	chk_ah_sets: assert property (@(posedge clk_i) disable iff (!resetn_i) // R02
		ev_ah |=> amplitude_high_flag_q) else $error("amp high flag not set");
	chk_al_sets: assert property (@(posedge clk_i) disable iff (!resetn_i) // R04
		ev_al |=> amplitude_low_flag_q) else $error("amp low flag not set");
	chk_zc_sets: assert property (@(posedge clk_i) disable iff (!resetn_i) // R05
		ev_zc |=> zero_count_flag_q) else $error("zero count flag not set");
	chk_err_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i) // R06
		watchdog_timeout_flag_q && !st_rd && !src_rd |=> watchdog_timeout_flag_q)
		else $error("error flag lost without read");
	chk_src_chan: assert property (@(posedge clk_i) disable iff (!resetn_i) // R07
		any_ev |=> error_source_channel_q == $past(ev_ch)) else $error("bad source");
	chk_resv_zero: assert property (@(posedge clk_i) disable iff (!resetn_i) // R08
		status_w[7] == 1'b0 && status_w[5:4] == 2'b00) else $error("reserved nonzero");
	chk_unread_set: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
		result_i[0] |=> status_w[3]) else $error("unread ch0 not set");
	chk_cfg_gate: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
		!errcfg_q[CFG_WD_INT] && !watchdog_timeout_flag_q |=> !watchdog_timeout_flag_q)
		else $error("gated watchdog flag set");
	chk_irq_flag: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
		result_ready_flag_q |-> !interrupt_out_n_o) else $error("irq not asserted");
endmodule
`default_nettype wire

// ---- csf_host.sv ----
// Host model issuing register and result word reads
`default_nettype none
module csf_host
	import csf_pkg::*;
(
	// Clock and read data
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	// Requests
	output var csf_req_s req_o,
	output var logic [3:0] rd_upper_o,
	output var logic [3:0] rd_lower_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_o = '0;
		rd_upper_o = '0;
		rd_lower_o = '0;
	end
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_i);
		req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clk_i);
		req_o = '0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_i);
		req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(negedge clk_i);
		req_o = '0;
		d = rdata_i;
	endtask
	// Both words fetched to retrieve a result
	task automatic word_rd(input int c);
		@(negedge clk_i);
		rd_upper_o[c] = 1'b1;
		@(negedge clk_i);
		rd_upper_o = '0;
		rd_lower_o[c] = 1'b1;
		@(negedge clk_i);
		rd_lower_o = '0;
	endtask
endmodule
`default_nettype wire

// ---- converter_status_flags_tb.sv ----
// Testbench for the converter status flag register bank
`default_nettype none
module converter_status_flags_tb
	import csf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	csf_req_s req;
	logic [15:0] rdata, got;
	logic [3:0] rd_up, rd_lo, act, res;
	logic seq, irq_n;
	logic [4:0] to_res;
	csf_err_s [3:0] err, e;
	int err_total = 0;
	int checks_done = 0;
	always #20 clk_i = ~clk_i;
	csf_status #(.NCH(4)) i_dut(.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
		.rdata_o(rdata), .rd_upper_i(rd_up), .rd_lower_i(rd_lo), .active_i(act),
		.sequential_i(seq), .result_i(res), .err_i(err), .under_range_i(1'b0),
		.over_range_i(1'b0), .to_result_o(to_res), .interrupt_out_n_o(irq_n));
	csf_host i_host(.clk_i(clk_i), .rdata_i(rdata), .req_o(req), .rd_upper_o(rd_up),
		.rd_lower_o(rd_lo));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
		checks_done++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic ev(input logic [3:0] r, input csf_err_s [3:0] v);
		@(negedge clk_i);
		res = r;
		err = v;
		@(negedge clk_i);
		res = '0;
		err = '0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		act = 4'hf;
		seq = 1'b0;
		res = '0;
		err = '0;
		repeat (10) @(posedge clk_i);
		@(negedge clk_i) resetn_i = 1'b1;
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("status_rst", 16'h0000, got);
		i_host.reg_rd(ERRCFG_ADDR, got);
		cmp("cfg_rst", 16'h0000, got);
		i_host.reg_wr(ERRCFG_ADDR, 16'hffff);
		i_host.reg_rd(ERRCFG_ADDR, got);
		cmp("cfg_rw", 16'hf8fd, got);
		cmp("to_result", 16'h001f, {11'h0, to_res});
		i_host.reg_wr(STATUS_ADDR, 16'hffff);
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("status_wr", 16'h0000, got);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			e = '0;
			e[i] = csf_err_s'(4'h8 >> i);
			ev(4'h0, e);
			cmp("irq_set", 16'h0000, {15'h0, irq_n});
			i_host.reg_rd(STATUS_ADDR, got);
			cmp("err_flag", {i[1:0], 2'b00, 4'h8 >> i, 8'h00}, got);
			i_host.reg_rd(STATUS_ADDR, got);
			cmp("err_clear", 16'h0000, got & 16'h0fff);
			cmp("irq_clear", 16'h0001, {15'h0, irq_n});
		end
		act = 4'he;
		ev(4'h0, {4'h0, 4'h0, 4'h0, 4'h8});
		act = 4'hf;
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("inactive", 16'h0000, got & 16'h0f00);
		i_host.reg_wr(ERRCFG_ADDR, 16'h0001);
		ev(4'h0, {4'h0, 4'h0, 4'h8, 4'h0});
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("masked", 16'h0000, got & 16'h0f00);
		i_host.reg_wr(ERRCFG_ADDR, 16'hffff);
		ev(4'h0, {4'h0, 4'h8, 4'h0, 4'h0});
		i_host.word_rd(2);
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("upper_clr", 16'h0000, got & 16'h0f00);
		$display("test errors done");
		for (int c = 0; c < 4; c++) begin
			ev(4'h1 << c, '0);
			i_host.reg_rd(STATUS_ADDR, got);
			// Source field still holds channel 2 from the last error
			cmp("unread", 16'h8040 | (16'h0008 >> c), got);
			i_host.word_rd(c);
			i_host.reg_rd(STATUS_ADDR, got);
			cmp("unread_clr", 16'h8000, got);
		end
		seq = 1'b1;
		act = 4'h3;
		ev(4'h1, '0);
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("seq_part", 16'h0000, got & 16'h0040);
		ev(4'h2, '0);
		i_host.reg_rd(STATUS_ADDR, got);
		cmp("seq_all", 16'h0040, got & 16'h0040);
		$display("test results done");
		give_verdict();
	end
endmodule
`default_nettype wire
